// *** core/ddc_defines.vh ***
// Constants for the dual code-controlled tap selector block.
// Included by the top design file by bare name; holds definitions only.
`ifndef DDC_DEFINES_VH
`define DDC_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DDC_OFS_CODE0 4'h0
`define DDC_OFS_CODE1 4'h2
`define DDC_OFS_STAT 4'h4

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define DDC_ADDR_W 4
`define DDC_DATA_W 16
`define DDC_CODE_W 8
`define DDC_TAPS 256
`define DDC_CODE_RST 8'h00

// ----------------------------------------
// Status register field positions
// ----------------------------------------
`define DDC_STAT_DRV0 0
`define DDC_STAT_DRV1 1
`define DDC_STAT_UPD0 2
`define DDC_STAT_UPD1 3
`define DDC_STAT_W 4

`endif

// *** core/ddc_tap_sel.v ***
// One channel's tap selector: registered one-hot tap enables.
// Assumes the code presented is the value the code register takes at this edge.
`timescale 1ns/10ps
`default_nettype none

module ddc_tap_sel #(
    parameter CODE_W = 8,
    parameter TAPS = 256
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire [CODE_W-1:0] code_nxt,
    input wire drive,
    // Tap enables
    output reg [TAPS-1:0] tap_r
);

    reg [TAPS-1:0] tap_nxt;
    integer i;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always @* begin
        tap_nxt = {TAPS{1'b0}};
        for (i = 0; i < TAPS; i = i + 1) begin
            if (drive && (code_nxt == i[CODE_W-1:0])) begin
                tap_nxt[i] = 1'b1;
            end
        end
    end

    // No tap at all while reset holds
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_r <= {TAPS{1'b0}};
        end else begin
            tap_r <= tap_nxt;
        end
    end

endmodule // ddc_tap_sel

`default_nettype wire

// *** core/ddc_top.v ***
// Functional notes
// - Two independent channels, each steered by its own 8-bit code register.
// - Code registers accept both byte and word writes and reads.
// - Reset clears each code register to zero and holds it there.
// - Exactly one of 256 taps is connected, index equal to the code.
// - While reset is asserted no tap is connected; outputs float.
// - A code write changes tap selection at once, no start command.
// - Selected tap holds until software writes that channel's code again.
// - After reset release each channel drives tap zero, the lower reference.
// - Output level is lower reference plus code times span over 256.
//
// Top of the dual code-controlled tap selector: register port and two channels.
// Assumes one clock, synchronous inputs and a master that never overlaps strobes.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defines.vh"

module ddc_top #(
    parameter CODE_W = `DDC_CODE_W,
    parameter TAPS = `DDC_TAPS
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [`DDC_ADDR_W-1:0] bus_addr,
    input wire [`DDC_DATA_W-1:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire bus_word,
    output reg [`DDC_DATA_W-1:0] bus_rdata_r,
    // Channel 0
    output reg [CODE_W-1:0] code0_r,
    output wire [TAPS-1:0] tap0_r,
    output reg drive0_r,
    // Channel 1
    output reg [CODE_W-1:0] code1_r,
    output wire [TAPS-1:0] tap1_r,
    output reg drive1_r
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Byte access to the odd half of a word hits nothing; word access
    // must be word aligned and only the low byte carries the code.
    wire odd_addr;
    wire hit_code0;
    wire hit_code1;
    wire hit_stat;
    wire wr_code0;
    wire wr_code1;
    wire rd_stat;

    assign odd_addr = bus_addr[0];
    assign hit_code0 = (bus_addr == `DDC_OFS_CODE0);
    assign hit_code1 = (bus_addr == `DDC_OFS_CODE1);
    assign hit_stat = (bus_addr == `DDC_OFS_STAT);
    assign wr_code0 = bus_wr && hit_code0 && !odd_addr;
    assign wr_code1 = bus_wr && hit_code1 && !odd_addr;
    assign rd_stat = bus_rd && hit_stat;

    // ----------------------------------------
    // Code registers
    // ----------------------------------------
    reg [CODE_W-1:0] code0_nxt;
    reg [CODE_W-1:0] code1_nxt;

    // Byte and word writes both land the low byte in the register
    always @* begin
        code0_nxt = code0_r;
        if (wr_code0) begin
            code0_nxt = bus_wdata[CODE_W-1:0];
        end
    end

    always @* begin
        code1_nxt = code1_r;
        if (wr_code1) begin
            code1_nxt = bus_wdata[CODE_W-1:0];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            code0_r <= `DDC_CODE_RST;
            code1_r <= `DDC_CODE_RST;
        end else begin
            code0_r <= code0_nxt;
            code1_r <= code1_nxt;
        end
    end

    // ----------------------------------------
    // Drive enables
    // ----------------------------------------
    // Low during reset so the pins float; high from the first edge after
    // release, where the code is still zero and the lower reference shows.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            drive0_r <= 1'b0;
            drive1_r <= 1'b0;
        end else begin
            drive0_r <= 1'b1;
            drive1_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Tap selectors
    // ----------------------------------------
    // Fed from the next code value so the tap moves on the same edge
    // as the register: no extra cycle of lag and no load command.
    // The string itself sets the level: lower ref plus code times span/256.
    ddc_tap_sel #(
        .CODE_W(CODE_W),
        .TAPS(TAPS)
    ) u_tap0 (
        .clk(clk),
        .rst(rst),
        .code_nxt(code0_nxt),
        .drive(1'b1),
        .tap_r(tap0_r)
    );

    ddc_tap_sel #(
        .CODE_W(CODE_W),
        .TAPS(TAPS)
    ) u_tap1 (
        .clk(clk),
        .rst(rst),
        .code_nxt(code1_nxt),
        .drive(1'b1),
        .tap_r(tap1_r)
    );

    // ----------------------------------------
    // Update flags
    // ----------------------------------------
    // Sticky per channel, cleared by a status read; a write in the
    // same cycle as the read keeps its flag so no update is missed.
    reg upd0_r;
    reg upd1_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            upd0_r <= 1'b0;
            upd1_r <= 1'b0;
        end else begin
            upd0_r <= wr_code0 | (upd0_r & ~rd_stat);
            upd1_r <= wr_code1 | (upd1_r & ~rd_stat);
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    reg [`DDC_DATA_W-1:0] rdata_nxt;
    reg [`DDC_STAT_W-1:0] stat_val;

    always @* begin
        stat_val = {`DDC_STAT_W{1'b0}};
        stat_val[`DDC_STAT_DRV0] = drive0_r;
        stat_val[`DDC_STAT_DRV1] = drive1_r;
        stat_val[`DDC_STAT_UPD0] = upd0_r;
        stat_val[`DDC_STAT_UPD1] = upd1_r;
    end

    // Unmapped or odd-byte reads answer zero; upper bits always zero
    always @* begin
        rdata_nxt = {`DDC_DATA_W{1'b0}};
        if (bus_rd && !odd_addr) begin
            if (hit_code0) begin
                rdata_nxt[CODE_W-1:0] = code0_r;
            end else if (hit_code1) begin
                rdata_nxt[CODE_W-1:0] = code1_r;
            end else if (hit_stat) begin
                rdata_nxt[`DDC_STAT_W-1:0] = stat_val;
            end
        end
    end

    // Data stand only in the cycle after the strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_rdata_r <= {`DDC_DATA_W{1'b0}};
        end else begin
            bus_rdata_r <= rdata_nxt;
        end
    end

endmodule // ddc_top

`default_nettype wire

// *** bench/ddc_cpu_model.sv ***
// Processor-side master for the code register port.
// Assumes callers run one request at a time.
`timescale 1ns/10ps
`default_nettype none
module ddc_cpu_model (
    // Clock
    input wire logic clk,
    // Register port
    output var logic [3:0] bus_addr,
    output var logic [15:0] bus_wdata,
    output var logic bus_wr,
    output var logic bus_rd,
    output var logic bus_word
);
    initial begin
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_word = 1'b0;
    end
    // Held one cycle; the next call replaces it, so no gap
    task op(input logic w, input logic [3:0] a, input logic [15:0] d, input logic wd);
        @(posedge clk);
        bus_wr <= w;
        bus_rd <= !w;
        bus_addr <= a;
        bus_wdata <= d;
        bus_word <= wd;
    endtask
    task idle();
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
    endtask
endmodule // ddc_cpu_model
`default_nettype wire

// *** bench/ddc_top_assertions.sv ***
// Checker on the ports of the tap selector top.
// Assumes one clock and an async active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ddc_chk #(parameter TAPS = 256) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_rdata_r,
    input wire logic [7:0] code0_r,
    input wire logic [TAPS-1:0] tap0_r,
    input wire logic drive0_r,
    input wire logic [7:0] code1_r,
    input wire logic [TAPS-1:0] tap1_r,
    input wire logic drive1_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Outputs are unknown until the first edge inside reset, so wait one
    logic rst_held_r = 1'b0;
    always @(posedge clk) rst_held_r <= rst;
    a_tap_code0: assert property (drive0_r |-> tap0_r == (TAPS'(1) << code0_r)) else $error("tap0 bad");
    a_tap_code1: assert property (drive1_r |-> tap1_r == (TAPS'(1) << code1_r)) else $error("tap1 bad");
    a_reset_float: assert property (disable iff (1'b0) rst && rst_held_r |-> !(tap0_r | tap1_r) && !drive0_r && !drive1_r
        && !(code0_r | code1_r)) else $error("reset state bad");
    a_write_now0: assert property (bus_wr && bus_addr == 4'h0 |=> code0_r == $past(bus_wdata[7:0]))
        else $error("code0 write");
    a_write_now1: assert property (bus_wr && bus_addr == 4'h2 |=> code1_r == $past(bus_wdata[7:0]))
        else $error("code1 write");
    a_code_hold0: assert property (!(bus_wr && bus_addr == 4'h0) |=> $stable(code0_r)) else $error("code0 moved");
    a_code_hold1: assert property (!(bus_wr && bus_addr == 4'h2) |=> $stable(code1_r)) else $error("code1 moved");
    a_drive_up: assert property (!$past(rst) |-> drive0_r && drive1_r) else $error("not driven");
    a_read_back: assert property (bus_rd && bus_addr == 4'h0 |=> bus_rdata_r == {8'h00, $past(code0_r)})
        else $error("read bad");
    a_rdata_idle: assert property (!bus_rd |=> bus_rdata_r == 16'h0000) else $error("rdata not idle");
endmodule // ddc_chk
bind ddc_top ddc_chk #(.TAPS(TAPS)) chk_u (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r), .code0_r(code0_r), .tap0_r(tap0_r),
    .drive0_r(drive0_r), .code1_r(code1_r), .tap1_r(tap1_r), .drive1_r(drive1_r));
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the dual tap selector top.
// Assumes the processor model drives the register port.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd_d = 1'b0;
    logic ch;
    logic [1:0] upd;
    logic [7:0] mdl [2];
    logic [15:0] q [$];
    int err_count = 0, checks = 0, cyc = 0, seed = 38500, v, i;
    wire [3:0] bus_addr;
    wire [15:0] bus_wdata, bus_rdata_r;
    wire bus_wr, bus_rd, bus_word, drive0_r, drive1_r;
    wire [7:0] code0_r, code1_r;
    wire [255:0] tap0_r, tap1_r;
    ddc_cpu_model m_u (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_word(bus_word));
    ddc_top dut_u (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_word(bus_word), .bus_rdata_r(bus_rdata_r), .code0_r(code0_r), .tap0_r(tap0_r),
        .drive0_r(drive0_r), .code1_r(code1_r), .tap1_r(tap1_r), .drive1_r(drive1_r));
    always #12.5 clk = ~clk;
    task chk(input string n, input logic [255:0] s, input logic [255:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task results();
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        q.push_back(e);
        m_u.op(1'b0, a, 16'h0000, 1'b1);
    endtask
    // Read data are settled by the falling edge after the answer edge
    always @(posedge clk) rd_d <= bus_rd;
    always @(negedge clk) begin
        if (rd_d) chk("rdata", bus_rdata_r, q.pop_front());
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 2; i++) begin
            mdl[0] = 8'h00;
            mdl[1] = 8'h00;
            upd = 2'b00;
            m_u.idle();
            rd(4'h0, 16'h0000);
            rd(4'h2, 16'h0000);
            rd(4'h4, 16'h0003);
            m_u.idle();
            @(negedge clk);
            chk("tap0", tap0_r, 256'h1);
            chk("tap1", tap1_r, 256'h1);
            if (i == 0) begin
                // Write then read back at once, the other channel left alone
                repeat (30) begin
                    v = $random(seed);
                    ch = v[16];
                    m_u.op(1'b1, {2'b00, ch, 1'b0}, v[15:0], v[17]);
                    mdl[ch] = v[7:0];
                    upd[ch] = 1'b1;
                    rd({2'b00, ch, 1'b0}, {8'h00, mdl[ch]});
                    @(negedge clk);
                    chk("tap", ch ? tap1_r : tap0_r, 256'h1 << v[7:0]);
                    chk("tap other", ch ? tap0_r : tap1_r, 256'h1 << mdl[!ch]);
                    rd({2'b00, !ch, 1'b0}, {8'h00, mdl[!ch]});
                end
                m_u.op(1'b1, 4'h1, 16'h00FF, 1'b0);
                m_u.op(1'b1, 4'h6, 16'h00FF, 1'b1);
                rd(4'h6, 16'h0000);
                // Status: odd and unmapped writes must not raise a flag
                rd(4'h4, {12'h000, upd, 2'b11});
                m_u.op(1'b1, 4'h2, 16'h5A3C, 1'b1);
                mdl[1] = 8'h3C;
                rd(4'h4, 16'h000B);
                rd(4'h4, 16'h0003);
                rd(4'h2, {8'h00, mdl[1]});
                rd(4'h0, {8'h00, mdl[0]});
                m_u.idle();
                m_u.idle();
                @(posedge clk);
                rst <= 1'b1;
                @(negedge clk);
                chk("float", tap0_r | tap1_r, 256'h0);
                chk("cleared", {drive0_r, drive1_r, code0_r, code1_r}, 256'h0);
                repeat (3) @(posedge clk);
                rst <= 1'b0;
            end
        end
        // Let the last read-data compare run before the verdict
        @(posedge clk);
        results();
    end
endmodule // tb
`default_nettype wire
